/* File: src/occfg_pkg.sv */
/*
  Constants, register map and types for the output channel divider and
  driver configuration block.
  Assumes a 32-bit AXI4-Lite master; each register sits at four times
  its index.
*/
package occfg_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_DRV_CFG    = 14'h050F;
  localparam logic [13:0] IDX_DIV1_LO    = 14'h0510;
  localparam logic [13:0] IDX_DIV1_HI    = 14'h0511;
  localparam logic [13:0] IDX_DIV2_LO    = 14'h0512;
  localparam logic [13:0] IDX_CTRL       = 14'h0513;
  localparam logic [13:0] IDX_DIV1_PHASE = 14'h0514;
  localparam logic [13:0] IDX_DIV2_PHASE = 14'h0515;

  localparam logic [2:0] SEL_DRV_CFG    = 3'h0;
  localparam logic [2:0] SEL_DIV1_LO    = 3'h1;
  localparam logic [2:0] SEL_DIV1_HI    = 3'h2;
  localparam logic [2:0] SEL_DIV2_LO    = 3'h3;
  localparam logic [2:0] SEL_CTRL       = 3'h4;
  localparam logic [2:0] SEL_DIV1_PHASE = 3'h5;
  localparam logic [2:0] SEL_DIV2_PHASE = 3'h6;
  localparam logic [2:0] SEL_NONE       = 3'h7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DRV_CFG = 8'h10;
  localparam logic [7:0] RST_DIV1_LO = 8'h03;
  localparam logic [1:0] RST_DIV_HI  = 2'h0;
  localparam logic [7:0] RST_DIV2_LO = 8'h00;
  localparam logic [2:0] RST_CTRL    = 3'h0;
  localparam logic [7:0] RST_PHASE   = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_DOUBLER = 4;
  localparam int CTRL_PD      = 3;
  localparam int CTRL_PRESEL  = 2;
  localparam int DRV_CMOS33   = 7;
  localparam int DRV_FMT_HI   = 6;
  localparam int DRV_FMT_LO   = 4;
  localparam int DRV_POL_P    = 3;
  localparam int DRV_POL_N    = 2;
  localparam int DRV_BOOST    = 1;
  localparam int DRV_EN       = 0;

  // ----------------------------------------------------------------
  // Format and mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] FMT_PD      = 3'h0;
  localparam logic [2:0] FMT_HSTL    = 3'h1;
  localparam logic [2:0] FMT_LVDS    = 3'h2;
  localparam logic [2:0] FMT_CMOS_PN = 3'h4;
  localparam logic [2:0] FMT_CMOS_P  = 3'h5;
  localparam logic [2:0] FMT_CMOS_N  = 3'h6;

  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam logic [2:0] MODE_HSTL   = 3'h1;
  localparam logic [2:0] MODE_LVDS   = 3'h2;
  localparam logic [2:0] MODE_CMOS18 = 3'h3;
  localparam logic [2:0] MODE_CMOS33 = 3'h4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {WR_IDLE, WR_RESP} occfg_wr_state_type;

endpackage : occfg_pkg

/* File: src/occfg_divider.sv */
/*
  One 10-bit channel divider with a phase preload.
  Assumes srcTick is a one-cycle pulse per source clock edge, synchronous
  to mclk; clear restarts the count from the phase value.
*/
`timescale 1ns/1ps
module occfg_divider
(
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       clear,
  input  wire logic       srcTick,
  input  wire logic [9:0] divValue,
  input  wire logic [7:0] phase,
  output logic            divTick,
  output logic            halfTick
);

  logic [9:0] cnt_ff;
  logic       divTick_ff;
  logic       halfTick_ff;
  logic       atEnd;

  assign atEnd    = (cnt_ff >= divValue);
  assign divTick  = divTick_ff;
  assign halfTick = halfTick_ff;

  // ----------------------------------------------------------------
  // Count value+1 source ticks per output tick
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n || clear)
      cnt_ff <= {2'h0, phase};
    else if (srcTick)
      cnt_ff <= atEnd ? 10'h000 : cnt_ff + 10'h001;
  end

  // Half tick lets the doubler emit a second edge mid-period
  always_ff @(posedge mclk)
  begin
    if (!reset_n || clear)
    begin
      divTick_ff  <= 1'b0;
      halfTick_ff <= 1'b0;
    end
    else
    begin
      divTick_ff  <= srcTick && atEnd;
      halfTick_ff <= srcTick && !atEnd && (cnt_ff == (divValue >> 1));
    end
  end

endmodule : occfg_divider

/* File: src/occfg_top.sv */
/*
  Output channel divider and driver configuration with AXI4-Lite slave.
  Assumes the prescaler outputs arrive as one-cycle ticks synchronous
  to mclk, and an AXI4-Lite master with 32-bit data.
  // Function
  // - First divider divides by value plus one
  // - First divider split low/high, resets to 3
  // - Second divider value plus one, high bits control
  // - Doubler doubles first divider, bypasses second
  // - Power-down bit stops the whole channel
  // - Control bit 2 picks prescaler source
  // - Polarity field sets P and N sense
  // - Code 110 drives N only; 111 reserved
  // - Drive bit picks strength; 1.8V CMOS low
  // - Bit 0 enables 1.8V driver, not 3.3V
  // - Each divider has eight-bit phase, reset zero
  // - Bit 7 selects 3.3V CMOS, ignores format
  // - Format codes off, HSTL, LVDS, CMOS variants
*/
`timescale 1ns/1ps
module occfg_top
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [15:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [15:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        rfDivOneTick,
  input  wire logic        rfDivTwoTick,
  output logic             outputPairFiveP,
  output logic             outputPairFiveN,
  output logic             outputPairFivePEn,
  output logic             outputPairFiveNEn,
  output logic [2:0]       driverMode,
  output logic             driveStrong,
  output logic             chanActive
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] regSel(input logic [15:0] addr);
    logic [13:0] idx;
    idx = addr[15:2];
    case (idx)
      occfg_pkg::IDX_DRV_CFG:    regSel = occfg_pkg::SEL_DRV_CFG;
      occfg_pkg::IDX_DIV1_LO:    regSel = occfg_pkg::SEL_DIV1_LO;
      occfg_pkg::IDX_DIV1_HI:    regSel = occfg_pkg::SEL_DIV1_HI;
      occfg_pkg::IDX_DIV2_LO:    regSel = occfg_pkg::SEL_DIV2_LO;
      occfg_pkg::IDX_CTRL:       regSel = occfg_pkg::SEL_CTRL;
      occfg_pkg::IDX_DIV1_PHASE: regSel = occfg_pkg::SEL_DIV1_PHASE;
      occfg_pkg::IDX_DIV2_PHASE: regSel = occfg_pkg::SEL_DIV2_PHASE;
      default:                   regSel = occfg_pkg::SEL_NONE;
    endcase
  endfunction : regSel

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  occfg_pkg::occfg_wr_state_type wrState_ff;

  logic        awready_ff;
  logic        wready_ff;
  logic        awHeld_ff;
  logic        wHeld_ff;
  logic [15:0] awAddr_ff;
  logic [7:0]  wByte_ff;
  logic        wLane_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  logic [7:0]  drvCfg_ff;
  logic [7:0]  div1Lo_ff;
  logic [1:0]  div1Hi_ff;
  logic [7:0]  div2Lo_ff;
  logic [1:0]  div2Hi_ff;
  logic [2:0]  ctrl_ff;
  logic [7:0]  div1Phase_ff;
  logic [7:0]  div2Phase_ff;
  logic        resync_ff;

  logic        wrFire;
  logic [2:0]  wrSel;
  logic [2:0]  rdSel;
  logic [7:0]  rdByte;

  logic        doubler;
  logic        powerDown;
  logic        srcTick;
  logic        d1Tick;
  logic        d1Half;
  logic        d2Tick;
  logic        finalTick;
  logic        chanClk_ff;

  logic        cmos33;
  logic [2:0]  fmt;
  logic        nxt_pEn;
  logic        nxt_nEn;
  logic        nxt_pVal;
  logic        nxt_nVal;
  logic [2:0]  nxt_mode;
  logic        outP_ff;
  logic        outN_ff;
  logic        outPEn_ff;
  logic        outNEn_ff;
  logic [2:0]  mode_ff;
  logic        strong_ff;
  logic        active_ff;

  assign wrFire = (wrState_ff == occfg_pkg::WR_IDLE) && awHeld_ff
                  && wHeld_ff;
  assign wrSel  = regSel(awAddr_ff);
  assign rdSel  = regSel(araddr);

  // ----------------------------------------------------------------
  // AXI write channels
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      wrState_ff <= occfg_pkg::WR_IDLE;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      awHeld_ff  <= 1'b0;
      wHeld_ff   <= 1'b0;
      awAddr_ff  <= 16'h0000;
      wByte_ff   <= 8'h00;
      wLane_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= occfg_pkg::RESP_OKAY;
    end
    else
    begin
      case (wrState_ff)
        occfg_pkg::WR_IDLE:
        begin
          if (awvalid && awready_ff)
          begin
            awHeld_ff  <= 1'b1;
            awAddr_ff  <= awaddr;
            awready_ff <= 1'b0;
          end
          if (wvalid && wready_ff)
          begin
            wHeld_ff  <= 1'b1;
            wByte_ff  <= wdata[7:0];
            wLane_ff  <= wstrb[0];
            wready_ff <= 1'b0;
          end
          if (wrFire)
          begin
            wrState_ff <= occfg_pkg::WR_RESP;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= (wrSel == occfg_pkg::SEL_NONE) ?
                          occfg_pkg::RESP_SLVERR : occfg_pkg::RESP_OKAY;
          end
        end
        occfg_pkg::WR_RESP:
        begin
          if (bready)
          begin
            wrState_ff <= occfg_pkg::WR_IDLE;
            bvalid_ff  <= 1'b0;
            awHeld_ff  <= 1'b0;
            wHeld_ff   <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
          end
        end
        default:
          wrState_ff <= occfg_pkg::WR_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file; only byte lane 0 carries data
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      drvCfg_ff    <= occfg_pkg::RST_DRV_CFG;
      div1Lo_ff    <= occfg_pkg::RST_DIV1_LO;
      div1Hi_ff    <= occfg_pkg::RST_DIV_HI;
      div2Lo_ff    <= occfg_pkg::RST_DIV2_LO;
      div2Hi_ff    <= occfg_pkg::RST_DIV_HI;
      ctrl_ff      <= occfg_pkg::RST_CTRL;
      div1Phase_ff <= occfg_pkg::RST_PHASE;
      div2Phase_ff <= occfg_pkg::RST_PHASE;
    end
    else if (wrFire && wLane_ff)
    begin
      case (wrSel)
        occfg_pkg::SEL_DRV_CFG:    drvCfg_ff    <= wByte_ff;
        occfg_pkg::SEL_DIV1_LO:    div1Lo_ff    <= wByte_ff;
        occfg_pkg::SEL_DIV1_HI:    div1Hi_ff    <= wByte_ff[1:0];
        occfg_pkg::SEL_DIV2_LO:    div2Lo_ff    <= wByte_ff;
        occfg_pkg::SEL_CTRL:
        begin
          div2Hi_ff <= wByte_ff[1:0];
          ctrl_ff   <= wByte_ff[4:2];
        end
        occfg_pkg::SEL_DIV1_PHASE: div1Phase_ff <= wByte_ff;
        occfg_pkg::SEL_DIV2_PHASE: div2Phase_ff <= wByte_ff;
        default:                   drvCfg_ff    <= drvCfg_ff;
      endcase
    end
  end

  // Restart dividers after any divider write so phase stays aligned
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      resync_ff <= 1'b0;
    else
      resync_ff <= wrFire && wLane_ff
                   && (wrSel != occfg_pkg::SEL_DRV_CFG)
                   && (wrSel != occfg_pkg::SEL_NONE);
  end

  // ----------------------------------------------------------------
  // AXI read channel
  // ----------------------------------------------------------------
  always_comb
  begin
    case (rdSel)
      occfg_pkg::SEL_DRV_CFG:    rdByte = drvCfg_ff;
      occfg_pkg::SEL_DIV1_LO:    rdByte = div1Lo_ff;
      occfg_pkg::SEL_DIV1_HI:    rdByte = {6'h00, div1Hi_ff};
      occfg_pkg::SEL_DIV2_LO:    rdByte = div2Lo_ff;
      occfg_pkg::SEL_CTRL:       rdByte = {3'h0, ctrl_ff, div2Hi_ff};
      occfg_pkg::SEL_DIV1_PHASE: rdByte = div1Phase_ff;
      occfg_pkg::SEL_DIV2_PHASE: rdByte = div2Phase_ff;
      default:                   rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= occfg_pkg::RESP_OKAY;
    end
    else if (arvalid && arready_ff)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= {24'h000000, rdByte};
      rresp_ff   <= (rdSel == occfg_pkg::SEL_NONE) ?
                    occfg_pkg::RESP_SLVERR : occfg_pkg::RESP_OKAY;
    end
    else if (rvalid_ff && rready)
    begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  assign doubler   = ctrl_ff[occfg_pkg::CTRL_DOUBLER - 2];
  assign powerDown = ctrl_ff[occfg_pkg::CTRL_PD - 2];
  assign srcTick   = ctrl_ff[occfg_pkg::CTRL_PRESEL - 2] ?
                     rfDivTwoTick : rfDivOneTick;

  occfg_divider u_firstDiv
  (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .clear    (powerDown || resync_ff),
    .srcTick  (srcTick),
    .divValue ({div1Hi_ff, div1Lo_ff}),
    .phase    (div1Phase_ff),
    .divTick  (d1Tick),
    .halfTick (d1Half)
  );

  // Second divider is held idle while bypassed
  occfg_divider u_secondDiv
  (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .clear    (powerDown || resync_ff || doubler),
    .srcTick  (d1Tick),
    .divValue ({div2Hi_ff, div2Lo_ff}),
    .phase    (div2Phase_ff),
    .divTick  (d2Tick),
    .halfTick ()
  );

  // Doubling with divide-by-1 merges both edges; no gain there
  assign finalTick = doubler ? (d1Tick || d1Half) : d2Tick;

  always_ff @(posedge mclk)
  begin
    if (!reset_n || powerDown)
      chanClk_ff <= 1'b0;
    else if (finalTick)
      chanClk_ff <= !chanClk_ff;
  end

  // ----------------------------------------------------------------
  // Output driver decode
  // ----------------------------------------------------------------
  assign cmos33 = drvCfg_ff[occfg_pkg::DRV_CMOS33];
  assign fmt    = drvCfg_ff[occfg_pkg::DRV_FMT_HI:occfg_pkg::DRV_FMT_LO];

  always_comb
  begin
    nxt_mode = occfg_pkg::MODE_OFF;
    nxt_pEn  = 1'b0;
    nxt_nEn  = 1'b0;
    nxt_pVal = chanClk_ff;
    nxt_nVal = !chanClk_ff;
    if (!powerDown && cmos33)
    begin
      nxt_mode = occfg_pkg::MODE_CMOS33;
      nxt_pEn  = 1'b1;
      nxt_nEn  = 1'b1;
    end
    else if (!powerDown && drvCfg_ff[occfg_pkg::DRV_EN])
    begin
      case (fmt)
        occfg_pkg::FMT_HSTL:
        begin
          nxt_mode = occfg_pkg::MODE_HSTL;
          nxt_pEn  = 1'b1;
          nxt_nEn  = 1'b1;
        end
        occfg_pkg::FMT_LVDS:
        begin
          nxt_mode = occfg_pkg::MODE_LVDS;
          nxt_pEn  = 1'b1;
          nxt_nEn  = 1'b1;
        end
        occfg_pkg::FMT_CMOS_PN:
        begin
          nxt_mode = occfg_pkg::MODE_CMOS18;
          nxt_pEn  = 1'b1;
          nxt_nEn  = 1'b1;
        end
        occfg_pkg::FMT_CMOS_P:
        begin
          nxt_mode = occfg_pkg::MODE_CMOS18;
          nxt_pEn  = 1'b1;
        end
        occfg_pkg::FMT_CMOS_N:
        begin
          nxt_mode = occfg_pkg::MODE_CMOS18;
          nxt_nEn  = 1'b1;
        end
        default:
          nxt_mode = occfg_pkg::MODE_OFF;
      endcase
    end
    // Polarity only has meaning on single-ended drivers
    if ((nxt_mode == occfg_pkg::MODE_CMOS18)
        || (nxt_mode == occfg_pkg::MODE_CMOS33))
    begin
      nxt_pVal = chanClk_ff ^ drvCfg_ff[occfg_pkg::DRV_POL_P];
      // N sense: inverted for codes 00 and 11 only
      nxt_nVal = chanClk_ff ^ (drvCfg_ff[occfg_pkg::DRV_POL_P]
                 ~^ drvCfg_ff[occfg_pkg::DRV_POL_N]);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      outP_ff   <= 1'b0;
      outN_ff   <= 1'b0;
      outPEn_ff <= 1'b0;
      outNEn_ff <= 1'b0;
      mode_ff   <= occfg_pkg::MODE_OFF;
      strong_ff <= 1'b0;
      active_ff <= 1'b0;
    end
    else
    begin
      outP_ff   <= nxt_pEn && nxt_pVal;
      outN_ff   <= nxt_nEn && nxt_nVal;
      outPEn_ff <= nxt_pEn;
      outNEn_ff <= nxt_nEn;
      mode_ff   <= nxt_mode;
      strong_ff <= drvCfg_ff[occfg_pkg::DRV_BOOST]
                   && (nxt_mode != occfg_pkg::MODE_OFF)
                   && (nxt_mode != occfg_pkg::MODE_CMOS18);
      active_ff <= !powerDown;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready           = awready_ff;
  assign wready            = wready_ff;
  assign bvalid            = bvalid_ff;
  assign bresp             = bresp_ff;
  assign arready           = arready_ff;
  assign rvalid            = rvalid_ff;
  assign rdata             = rdata_ff;
  assign rresp             = rresp_ff;
  assign outputPairFiveP   = outP_ff;
  assign outputPairFiveN   = outN_ff;
  assign outputPairFivePEn = outPEn_ff;
  assign outputPairFiveNEn = outNEn_ff;
  assign driverMode        = mode_ff;
  assign driveStrong       = strong_ff;
  assign chanActive        = active_ff;

endmodule : occfg_top

/* File: testbench/occfg_clock_receiver.sv */
/*
  Downstream clock receiver: measures the P pin period in mclk cycles.
  Assumes the pin is sampled on mclk; an undriven pin is pulled low.
*/
`timescale 1ns/1ps
module occfg_clock_receiver
(
  input  wire logic        mclk,
  input  wire logic        pin,
  input  wire logic        pinEn,
  output logic      [15:0] period
);
  logic        prev = 1'b0;
  logic [15:0] cnt  = 16'h0;

  // Released pin reads low, as through a pull-down
  always @(posedge mclk)
  begin
    prev <= pinEn & pin;
    cnt  <= cnt + 16'h1;
    if ((pinEn & pin) && !prev)
    begin
      period <= cnt + 16'h1;
      cnt    <= 16'h0;
    end
  end
endmodule : occfg_clock_receiver

/* File: testbench/occfg_top_sva.sv */
/*
  Port checks for occfg_top.
  Assumes one clock domain, mclk, with synchronous reset_n.
*/
`timescale 1ns/1ps
module occfg_top_sva
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        outputPairFiveP,
  input wire logic        outputPairFiveN,
  input wire logic        outputPairFivePEn,
  input wire logic        outputPairFiveNEn,
  input wire logic [2:0]  driverMode,
  input wire logic        driveStrong
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_write_latency:
    assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response not on time");
  a_bresp_held:
    assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  a_read_latency:
    assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data not on time");
  a_rdata_stable:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed while waiting");
  a_rdata_upper:
    assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_pin_idle:
    assert property ((outputPairFivePEn || !outputPairFiveP)
                     && (outputPairFiveNEn || !outputPairFiveN))
    else $error("undriven pin not low");
  a_off_no_drive:
    assert property (driverMode == occfg_pkg::MODE_OFF
                     |-> !outputPairFivePEn && !outputPairFiveNEn)
    else $error("pins driven while off");
  a_cmos18_weak:
    assert property (driverMode == occfg_pkg::MODE_CMOS18 |-> !driveStrong)
    else $error("strong drive in low voltage cmos");
  a_cmos33_both:
    assert property (driverMode == occfg_pkg::MODE_CMOS33
                     |-> outputPairFivePEn && outputPairFiveNEn)
    else $error("high voltage cmos not on both pins");
  a_diff_pair:
    assert property ($stable(driverMode) && outputPairFivePEn
                     && (driverMode == occfg_pkg::MODE_HSTL
                     || driverMode == occfg_pkg::MODE_LVDS)
                     |-> outputPairFiveN != outputPairFiveP)
    else $error("differential pins not complementary");
endmodule : occfg_top_sva

bind occfg_top occfg_top_sva chk_i
(
  .mclk(mclk), .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .outputPairFiveP(outputPairFiveP),
  .outputPairFiveN(outputPairFiveN),
  .outputPairFivePEn(outputPairFivePEn),
  .outputPairFiveNEn(outputPairFiveNEn),
  .driverMode(driverMode), .driveStrong(driveStrong)
);

/* File: testbench/occfg_top_test.sv */
/*
  Self-checking bench for occfg_top: registers, driver modes, periods.
  Assumes the checker binds itself; ticks come every 2 and 3 cycles.
*/
`timescale 1ns/1ps
module occfg_top_test;
  logic        mclk, reset_n, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, driveStrong;
  logic        rfDivOneTick, rfDivTwoTick, pinP, pinN, pinPEn, pinNEn;
  logic        chanActive;
  logic [15:0] awaddr, araddr, period;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [2:0]  driverMode, tickCnt;
  logic [1:0]  bresp, rresp;
  int          mismatches, checksDone, cycles;
  logic [7:0]  rstTab [7] = '{8'h10, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  cfgTab [12] = '{8'h10, 8'h11, 8'h13, 8'h23, 8'h43, 8'h51,
                               8'h61, 8'h71, 8'h01, 8'h31, 8'hC2, 8'h90};
  // Expected {mode, pEn, nEn, strong}
  logic [5:0]  modeTab [12] = '{6'h00, 6'h0E, 6'h0F, 6'h17, 6'h1E, 6'h1C,
                                6'h1A, 6'h00, 6'h00, 6'h00, 6'h27, 6'h26};

  occfg_top uut
  (
    .mclk(mclk), .reset_n(reset_n), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rfDivOneTick(rfDivOneTick),
    .rfDivTwoTick(rfDivTwoTick), .outputPairFiveP(pinP),
    .outputPairFiveN(pinN), .outputPairFivePEn(pinPEn),
    .outputPairFiveNEn(pinNEn), .driverMode(driverMode),
    .driveStrong(driveStrong), .chanActive(chanActive)
  );

  occfg_clock_receiver rx
  (
    .mclk(mclk), .pin(pinP), .pinEn(pinPEn), .period(period)
  );

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    tickCnt      <= (tickCnt == 3'h5) ? 3'h0 : tickCnt + 3'h1;
    rfDivOneTick <= ~tickCnt[0];
    rfDivTwoTick <= (tickCnt == 3'h0) || (tickCnt == 3'h3);
    cycles       <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      final_report();
    end
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_write(input logic [13:0] idx, input logic [7:0] val,
                           input logic [1:0] expResp);
    awaddr  <= {idx, 2'h0};
    wdata   <= {24'h0, val};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk({32'h0, bresp}, {32'h0, expResp});
    @(posedge mclk);
  endtask : axi_write

  task automatic axi_read(input logic [13:0] idx, input logic [33:0] exp);
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk({rresp, rdata}, exp);
    @(posedge mclk);
  endtask : axi_read

  task automatic expect_period(input int t);
    repeat (3 * t + 40) @(posedge mclk);
    chk({18'h0, period}, {18'h0, t[15:0]});
  endtask : expect_period

  task automatic final_report();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  initial
  begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {rfDivOneTick, rfDivTwoTick, tickCnt} = '0;
    wstrb = 4'h1;
    reset_n = 1'b0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 7; i++)
      axi_read(14'(occfg_pkg::IDX_DRV_CFG + i), {26'h0, rstTab[i]});
    axi_read(14'h0516, {2'h2, 32'h0});
    axi_write(14'h0516, 8'h01, 2'h2);
    axi_write(occfg_pkg::IDX_DIV1_HI, 8'hFF, 2'h0);
    axi_read(occfg_pkg::IDX_DIV1_HI, 34'h3);
    axi_write(occfg_pkg::IDX_CTRL, 8'hFF, 2'h0);
    axi_read(occfg_pkg::IDX_CTRL, 34'h1F);
    axi_write(occfg_pkg::IDX_DIV1_PHASE, 8'hA5, 2'h0);
    axi_read(occfg_pkg::IDX_DIV1_PHASE, 34'hA5);
    wstrb <= 4'h0;
    axi_write(occfg_pkg::IDX_DIV2_PHASE, 8'h5A, 2'h0);
    wstrb <= 4'h1;
    axi_read(occfg_pkg::IDX_DIV2_PHASE, 34'h0);
    axi_write(occfg_pkg::IDX_DIV1_HI, 8'h00, 2'h0);
    axi_write(occfg_pkg::IDX_CTRL, 8'h00, 2'h0);
    $display("test registers done");
    for (int i = 0; i < 12; i++)
    begin
      axi_write(occfg_pkg::IDX_DRV_CFG, cfgTab[i], 2'h0);
      repeat (4) @(posedge mclk);
      chk({28'h0, driverMode, pinPEn, pinNEn, driveStrong},
          {28'h0, modeTab[i]});
    end
    // Equal P and N only for polarity codes 01 and 11
    for (int i = 0; i < 4; i++)
    begin
      axi_write(occfg_pkg::IDX_DRV_CFG, 8'h41 | 8'(i << 2), 2'h0);
      repeat (4) @(posedge mclk);
      chk({33'h0, pinP ^ pinN}, {33'h0, ~i[0]});
    end
    $display("test driver done");
    axi_write(occfg_pkg::IDX_DRV_CFG, 8'h11, 2'h0);
    expect_period(16);
    axi_write(occfg_pkg::IDX_DIV1_HI, 8'h01, 2'h0);
    axi_write(occfg_pkg::IDX_DIV1_LO, 8'h00, 2'h0);
    expect_period(1028);
    axi_write(occfg_pkg::IDX_DIV1_HI, 8'h00, 2'h0);
    axi_write(occfg_pkg::IDX_DIV1_LO, 8'h03, 2'h0);
    axi_write(occfg_pkg::IDX_DIV2_LO, 8'h02, 2'h0);
    expect_period(48);
    axi_write(occfg_pkg::IDX_CTRL, 8'h10, 2'h0);
    expect_period(8);
    axi_write(occfg_pkg::IDX_CTRL, 8'h04, 2'h0);
    expect_period(72);
    chk({33'h0, chanActive}, 34'h1);
    axi_write(occfg_pkg::IDX_CTRL, 8'h08, 2'h0);
    repeat (4) @(posedge mclk);
    chk({26'h0, chanActive, driverMode, pinP, pinN, pinPEn, pinNEn},
        34'h0);
    $display("test clock path done");
    final_report();
  end
endmodule : occfg_top_test
